// ### irq_ctrl_pkg.sv
// Package with the constants, types and register map of the interrupt control block.
package irq_ctrl_pkg;

    localparam int PC_W = 13;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_ENA   = 8'h04;
    localparam logic [7:0] OFF_ENB   = 8'h08;
    localparam logic [7:0] OFF_FLA   = 8'h0C;
    localparam logic [7:0] OFF_FLB   = 8'h10;
    localparam logic [7:0] OFF_OPT   = 8'h14;
    localparam logic [7:0] OFF_STAT  = 8'h18;

    // Field positions inside irq_control_reg; B_EDGE is the bit inside option_reg.
    localparam int B_GLOBAL_EN = 7;
    localparam int B_GROUP_EN  = 6;
    localparam int B_T0IE      = 5;
    localparam int B_EXTIE     = 4;
    localparam int B_PCIE      = 3;
    localparam int B_T0IF      = 2;
    localparam int B_EXTIF     = 1;
    localparam int B_PCIF      = 0;
    localparam int B_EDGE      = 0;

    // Reset values and implemented-bit masks.
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_EN   = 8'h00;
    localparam logic [7:0] RST_FL   = 8'h00;
    localparam logic [7:0] RST_OPT  = 8'h01;
    localparam logic [7:0] MASK_B   = 8'hF1;

    // Fixed interrupt vector.
    localparam logic [PC_W-1:0] VECTOR = 13'h0004;

    // Last phase of the instruction cycle (four phases).
    localparam logic [1:0] PH_LAST = 2'h3;

    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // Entry sequencer states, Gray coded along idle-post-flush-vector.
    typedef enum logic [1:0] {
        S_IDLE   = 2'b00,
        S_POST   = 2'b01,
        S_FLUSH  = 2'b11,
        S_VECTOR = 2'b10
    } seq_state_t;

    // One-clock event pulses of the peripheral-group sources.
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
    } periph_evt_t;

    // Commands to the core sequencer, one-clock pulses with address.
    typedef struct packed {
        logic            flush;
        logic            push;
        logic            pop;
        logic            load;
        logic [PC_W-1:0] addr;
        logic [PC_W-1:0] push_addr;
    } core_cmd_t;

endpackage

// ### vectored_interrupt_control.sv
// Interrupt control logic: flags, enables, entry sequencer, wake and AXI4-Lite registers.
`timescale 1ns/1ps

module vectored_interrupt_control (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic [31:0]               awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [31:0]               araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    input  wire logic                      timer_zero_ovf_evt,
    input  wire logic                      port_change_evt,
    input  wire logic                      ext_pin,
    input  wire irq_ctrl_pkg::periph_evt_t periph_evt,
    input  wire logic                      sleep_mode,
    input  wire logic                      return_from_isr_instr,
    input  wire logic [12:0]               cur_pc,
    input  wire logic [12:0]               stack_top,
    output irq_ctrl_pkg::core_cmd_t        core_cmd,
    output logic                           irq_request,
    output logic                           wake
);

    logic [7:0]               irq_control_reg;
    logic [7:0]               periph_enable_reg_a;
    logic [7:0]               periph_enable_reg_b;
    logic [7:0]               periph_flag_reg_a;
    logic [7:0]               periph_flag_reg_b;
    logic [7:0]               option_reg;
    logic [1:0]               phase;
    logic                     phase_one;
    logic                     pin_s1;
    logic                     pin_s2;
    logic                     pin_d;
    logic [2:0]               pin_live;
    logic                     edge_hit;
    logic                     pend;
    irq_ctrl_pkg::seq_state_t state;
    logic                     aw_held;
    logic                     w_held;
    logic [31:0]              aw_addr_q;
    logic [31:0]              w_data_q;
    logic                     w_lane0;
    logic                     do_write;
    logic [7:0]               wbyte;

    // Byte address of a register matches a printed offset.
    function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
        hit = (a == {24'h000000, off});
    endfunction

    // Any implemented register at this address.
    function automatic logic mapped(input logic [31:0] a);
        mapped = hit(a, irq_ctrl_pkg::OFF_CTRL) || hit(a, irq_ctrl_pkg::OFF_ENA)
              || hit(a, irq_ctrl_pkg::OFF_ENB) || hit(a, irq_ctrl_pkg::OFF_FLA)
              || hit(a, irq_ctrl_pkg::OFF_FLB) || hit(a, irq_ctrl_pkg::OFF_OPT)
              || hit(a, irq_ctrl_pkg::OFF_STAT);
    endfunction

    // Four-phase instruction cycle; phase one opens each cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase <= 2'h0;
        end else begin
            phase <= (phase == irq_ctrl_pkg::PH_LAST) ? 2'h0 : phase + 2'h1;
        end
    end
    assign phase_one = (phase == 2'h0);

    // The pin is asynchronous, so it is synchronised before the edge detector.
    // The live bits hold the detector off until all three stages carry the pin,
    // so a pin that idles high gives no false rising edge after reset.
    // synchronised pin entry path
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1   <= 1'b0;
            pin_s2   <= 1'b0;
            pin_d    <= 1'b0;
            pin_live <= 3'h0;
        end else begin
            pin_s1   <= ext_pin;
            pin_s2   <= pin_s1;
            pin_d    <= pin_s2;
            pin_live <= {pin_live[1:0], 1'b1};
        end
    end

    assign edge_hit = pin_live[2] && (option_reg[irq_ctrl_pkg::B_EDGE] ? (pin_s2 & ~pin_d)
                                                                     : (~pin_s2 & pin_d));

    assign pend = |(irq_control_reg[5:3] & irq_control_reg[2:0])
               || (irq_control_reg[irq_ctrl_pkg::B_GROUP_EN]
                   && |((periph_enable_reg_a & periph_flag_reg_a)
                        | (periph_enable_reg_b & periph_flag_reg_b)));

    assign wbyte    = w_data_q[7:0];
    assign do_write = aw_held && w_held && !bvalid;

    // Write address channel: one address held until its response is taken.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awready   <= 1'b0;
            aw_held   <= 1'b0;
            aw_addr_q <= 32'h00000000;
        end else if (awvalid && awready) begin
            awready   <= 1'b0;
            aw_held   <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end else if (!aw_held && !bvalid) begin
            awready <= 1'b1;
        end
    end

    // Write data channel, taken independently of the address.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wready   <= 1'b0;
            w_held   <= 1'b0;
            w_data_q <= 32'h00000000;
            w_lane0  <= 1'b0;
        end else if (wvalid && wready) begin
            wready   <= 1'b0;
            w_held   <= 1'b1;
            w_data_q <= wdata;
            w_lane0  <= wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end else if (!w_held && !bvalid) begin
            wready <= 1'b1;
        end
    end

    // Write response; an unmapped address answers with a slave error.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bvalid <= 1'b0;
            bresp  <= irq_ctrl_pkg::RESP_OK;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= mapped(aw_addr_q) ? irq_ctrl_pkg::RESP_OK : irq_ctrl_pkg::RESP_ERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read channel; only one read is outstanding, so arready drops meanwhile.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= irq_ctrl_pkg::RESP_OK;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= mapped(araddr) ? irq_ctrl_pkg::RESP_OK : irq_ctrl_pkg::RESP_ERR;
            rdata   <= 32'h00000000;
            if (hit(araddr, irq_ctrl_pkg::OFF_CTRL)) rdata[7:0] <= irq_control_reg;
            if (hit(araddr, irq_ctrl_pkg::OFF_ENA))  rdata[7:0] <= periph_enable_reg_a;
            if (hit(araddr, irq_ctrl_pkg::OFF_ENB))  rdata[7:0] <= periph_enable_reg_b;
            if (hit(araddr, irq_ctrl_pkg::OFF_FLA))  rdata[7:0] <= periph_flag_reg_a;
            if (hit(araddr, irq_ctrl_pkg::OFF_FLB))  rdata[7:0] <= periph_flag_reg_b;
            if (hit(araddr, irq_ctrl_pkg::OFF_OPT))  rdata[7:0] <= option_reg;
            if (hit(araddr, irq_ctrl_pkg::OFF_STAT)) begin
                rdata[4:0] <= {state, wake, irq_request, irq_control_reg[7]};
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // Entry sequencer, stepped only at phase one so latency is whole cycles.
    // three-cycle entry timing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= irq_ctrl_pkg::S_IDLE;
        end else if (phase_one) begin
            case (state)
                irq_ctrl_pkg::S_IDLE: begin
                    // wake vectors only with global enable
                    if (irq_control_reg[irq_ctrl_pkg::B_GLOBAL_EN] && pend) begin
                        state <= sleep_mode ? irq_ctrl_pkg::S_POST : irq_ctrl_pkg::S_FLUSH;
                    end
                end
                irq_ctrl_pkg::S_POST:   state <= irq_ctrl_pkg::S_FLUSH;
                irq_ctrl_pkg::S_FLUSH:  state <= irq_ctrl_pkg::S_VECTOR;
                irq_ctrl_pkg::S_VECTOR: state <= irq_ctrl_pkg::S_IDLE;
                default:                state <= irq_ctrl_pkg::S_IDLE;
            endcase
        end
    end

    // Core commands: pulses of one clock, entry steps at the phase-one edge, return pop/load at any edge with no entry step.
    // only return address saved
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_cmd <= '0;
        end else begin
            core_cmd.flush <= 1'b0;
            core_cmd.push  <= 1'b0;
            core_cmd.pop   <= 1'b0;
            core_cmd.load  <= 1'b0;
            if (phase_one && state == irq_ctrl_pkg::S_POST) begin
                core_cmd.flush <= 1'b1;
            end else if (phase_one && state == irq_ctrl_pkg::S_IDLE
                         && irq_control_reg[irq_ctrl_pkg::B_GLOBAL_EN] && pend
                         && !sleep_mode) begin
                core_cmd.flush <= 1'b1;
            end else if (phase_one && state == irq_ctrl_pkg::S_FLUSH) begin
                core_cmd.push      <= 1'b1;
                core_cmd.push_addr <= cur_pc;
                core_cmd.load      <= 1'b1;
                core_cmd.addr      <= irq_ctrl_pkg::VECTOR;
            end else if (return_from_isr_instr) begin
                core_cmd.pop  <= 1'b1;
                core_cmd.load <= 1'b1;
                core_cmd.addr <= stack_top;
            end
        end
    end

    // Request and wake outputs are registered so the core sees clean levels.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_request <= 1'b0;
            wake        <= 1'b0;
        end else begin
            irq_request <= irq_control_reg[irq_ctrl_pkg::B_GLOBAL_EN] && pend;
            wake        <= sleep_mode && pend;
        end
    end

    // Control register: software write, then entry/return, then events win.
    // reset disables all
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_control_reg <= irq_ctrl_pkg::RST_CTRL;
        end else begin
            irq_control_reg <= next_ctrl();
        end
    end

    function automatic logic [7:0] next_ctrl();
        logic [7:0] c;
        c = irq_control_reg;
        if (do_write && w_lane0 && hit(aw_addr_q, irq_ctrl_pkg::OFF_CTRL)) c = wbyte;
        if (return_from_isr_instr) c[irq_ctrl_pkg::B_GLOBAL_EN] = 1'b1;
        // Entry clears the global enable in the same cycle as the flush; the stored bit
        // is tested, as in the sequencer, so no clear can happen without an entry.
        if (phase_one && (state == irq_ctrl_pkg::S_POST
            || (state == irq_ctrl_pkg::S_IDLE
                && irq_control_reg[irq_ctrl_pkg::B_GLOBAL_EN] && pend
                && !sleep_mode))) begin
            c[irq_ctrl_pkg::B_GLOBAL_EN] = 1'b0;
        end
        c[irq_ctrl_pkg::B_T0IF]  = c[irq_ctrl_pkg::B_T0IF]  | timer_zero_ovf_evt;
        c[irq_ctrl_pkg::B_EXTIF] = c[irq_ctrl_pkg::B_EXTIF] | edge_hit;
        c[irq_ctrl_pkg::B_PCIF]  = c[irq_ctrl_pkg::B_PCIF]  | port_change_evt;
        next_ctrl = c;
    endfunction

    // Peripheral enables, flags and the edge select; group b has five live bits.
    // thirteen enable and flag pairs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            periph_enable_reg_a <= irq_ctrl_pkg::RST_EN;
            periph_enable_reg_b <= irq_ctrl_pkg::RST_EN;
            periph_flag_reg_a   <= irq_ctrl_pkg::RST_FL;
            periph_flag_reg_b   <= irq_ctrl_pkg::RST_FL;
            option_reg          <= irq_ctrl_pkg::RST_OPT;
        end else begin
            if (do_write && w_lane0 && hit(aw_addr_q, irq_ctrl_pkg::OFF_ENA)) begin
                periph_enable_reg_a <= wbyte;
            end
            if (do_write && w_lane0 && hit(aw_addr_q, irq_ctrl_pkg::OFF_ENB)) begin
                periph_enable_reg_b <= wbyte & irq_ctrl_pkg::MASK_B;
            end
            if (do_write && w_lane0 && hit(aw_addr_q, irq_ctrl_pkg::OFF_OPT)) begin
                option_reg <= {7'h00, wbyte[irq_ctrl_pkg::B_EDGE]};
            end
            // Set wins over a same-cycle clear so no event is lost.
            if (do_write && w_lane0 && hit(aw_addr_q, irq_ctrl_pkg::OFF_FLA)) begin
                periph_flag_reg_a <= wbyte | periph_evt.a;
            end else begin
                periph_flag_reg_a <= periph_flag_reg_a | periph_evt.a;
            end
            if (do_write && w_lane0 && hit(aw_addr_q, irq_ctrl_pkg::OFF_FLB)) begin
                periph_flag_reg_b <= (wbyte | periph_evt.b) & irq_ctrl_pkg::MASK_B;
            end else begin
                periph_flag_reg_b <= (periph_flag_reg_b | periph_evt.b) & irq_ctrl_pkg::MASK_B;
            end
        end
    end

    a_reset_off: assert property (@(posedge clk) $rose(nrst) |-> irq_control_reg == 8'h00)
        else $error("control not cleared by reset");

    a_flag_sets: assert property (@(posedge clk) disable iff (!nrst)
        timer_zero_ovf_evt |=> irq_control_reg[2])
        else $error("timer flag lost");

    a_req_gated: assert property (@(posedge clk) disable iff (!nrst)
        irq_request |-> $past(irq_control_reg[7]))
        else $error("request without global enable");

    a_flush_clear: assert property (@(posedge clk) disable iff (!nrst)
        core_cmd.flush |-> !irq_control_reg[7] || $past(return_from_isr_instr))
        else $error("flush left global enable set");

    a_vector_load: assert property (@(posedge clk) disable iff (!nrst)
        core_cmd.push |-> core_cmd.load && core_cmd.addr == 13'h0004)
        else $error("push without vector load");

    a_entry_time: assert property (@(posedge clk) disable iff (!nrst)
        core_cmd.flush |-> ##4 core_cmd.push)
        else $error("vector not one cycle after flush");

    a_return_gie: assert property (@(posedge clk) disable iff (!nrst)
        return_from_isr_instr && !phase_one |=> irq_control_reg[7] && core_cmd.pop)
        else $error("return did not pop and enable");

    a_pend_served: assert property (@(posedge clk) disable iff (!nrst)
        phase_one && state == irq_ctrl_pkg::S_IDLE && irq_control_reg[7] && pend
        && !sleep_mode |=> core_cmd.flush)
        else $error("pending interrupt not taken");

    a_sleep_exec: assert property (@(posedge clk) disable iff (!nrst)
        $rose(state == irq_ctrl_pkg::S_POST) |-> !core_cmd.flush ##4 core_cmd.flush)
        else $error("instruction after sleep skipped");

    a_edge_flag: assert property (@(posedge clk) disable iff (!nrst)
        edge_hit |=> irq_control_reg[1])
        else $error("pin edge did not set flag");

endmodule

// ### irq_core_model.sv
// Core sequencer model: holds the program counter and a small return stack.
`timescale 1ns/1ps

module irq_core_model (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire irq_ctrl_pkg::core_cmd_t core_cmd,
    output logic [12:0]                  cur_pc,
    output logic [12:0]                  stack_top,
    output logic [7:0]                   n_load
);
    logic [12:0] stack [0:7];
    logic [2:0]  sp;

    // The counter stands still between loads, so every pushed address is known in advance.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_pc <= 13'h0123;
            n_load <= 8'h00;
        end else if (core_cmd.load) begin
            cur_pc <= core_cmd.addr;
            n_load <= n_load + 8'h01;
        end
    end

    // context left to routine
    // Only return addresses are stacked; working registers are the routine's own job.
    // The pointer wraps silently after eight pushes, as a hardware stack does.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sp <= 3'h0;
        end else if (core_cmd.push) begin
            stack[sp] <= core_cmd.push_addr;
            sp <= sp + 3'h1;
        end else if (core_cmd.pop) begin
            sp <= sp - 3'h1;
        end
    end

    // An empty stack shows a fixed junk pattern rather than a stale entry.
    assign stack_top = (sp == 3'h0) ? 13'h1ABC : stack[sp-3'h1];
endmodule

// ### vectored_interrupt_control_tb.sv
// Self-checking bench for the interrupt control block, driven over AXI4-Lite.
`timescale 1ns/1ps

module vectored_interrupt_control_tb;
    logic                    clk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic                    awready, wready, bvalid, arready, rvalid, ext_pin, sleep_mode;
    logic                    irq_request, wake;
    logic [31:0]             awaddr, wdata, araddr, rdata;
    logic [3:0]              wstrb, ev;
    logic [1:0]              bresp, rresp;
    logic [12:0]             cur_pc, stack_top;
    logic [7:0]              n_load;
    irq_ctrl_pkg::core_cmd_t core_cmd;
    int                      fail_count, n_tests, cyc;

    vectored_interrupt_control u_vectored_interrupt_control (
        .clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timer_zero_ovf_evt(ev[0]), .port_change_evt(ev[3]), .ext_pin(ext_pin),
        .periph_evt({7'h00, ev[2], 8'h00}), .sleep_mode(sleep_mode),
        .return_from_isr_instr(ev[1]), .cur_pc(cur_pc), .stack_top(stack_top),
        .core_cmd(core_cmd), .irq_request(irq_request), .wake(wake));

    irq_core_model u_irq_core_model (
        .clk(clk), .nrst(nrst), .core_cmd(core_cmd), .cur_pc(cur_pc),
        .stack_top(stack_top), .n_load(n_load));

    // Free-running clock, 10 ns period.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
            fail_count++;
        end
    endtask

    // Address and data go out together and each is dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= {24'h000000, a};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        check("write resp", {30'h0, bresp}, {30'h0, irq_ctrl_pkg::RESP_OK});
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= {24'h000000, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        check(n, d, e);
        check({n, " resp"}, {30'h0, r}, {30'h0, irq_ctrl_pkg::RESP_OK});
    endtask

    // One-clock event pulse on the selected source.
    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
    endtask

    // Waits a bounded time for the core to see the expected number of loads, vector and return alike.
    task automatic wait_load(input logic [7:0] n);
        for (int i = 0; i < 16 && n_load !== n; i++) @(posedge clk);
        check("load count", {24'h0, n_load}, {24'h0, n});
    endtask

    // Cuts a hang short; the whole sequence needs well under a thousand cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        {awvalid, wvalid, bready, arvalid, rready, sleep_mode, nrst} = 7'h00;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hF;
        ev = 4'h0;
        ext_pin = 1'b1;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        chk_rd("ctrl reset", irq_ctrl_pkg::OFF_CTRL, 32'h00);
        chk_rd("option reset", irq_ctrl_pkg::OFF_OPT, 32'h01);
        rd(8'h1C, d, r);
        check("unmapped resp", {30'h0, r}, {30'h0, irq_ctrl_pkg::RESP_ERR});
        pulse(0);
        pulse(3);
        chk_rd("flag disabled", irq_ctrl_pkg::OFF_CTRL, 32'h05);
        check("no request", {31'h0, irq_request}, 32'h0);
        wr(irq_ctrl_pkg::OFF_CTRL, 8'h00);
        chk_rd("flag cleared", irq_ctrl_pkg::OFF_CTRL, 32'h00);
        wr(irq_ctrl_pkg::OFF_CTRL, 8'hA0);
        pulse(0);
        wait_load(8'h01);
        check("vector", {19'h0, cur_pc}, 32'h0004);
        check("pushed pc", {19'h0, stack_top}, 32'h0123);
        chk_rd("entry ctrl", irq_ctrl_pkg::OFF_CTRL, 32'h24);
        wr(irq_ctrl_pkg::OFF_CTRL, 8'h20);
        pulse(1);
        wait_load(8'h02);
        check("return pc", {19'h0, cur_pc}, 32'h0123);
        chk_rd("return ctrl", irq_ctrl_pkg::OFF_CTRL, 32'hA0);
        wr(irq_ctrl_pkg::OFF_ENA, 8'h01);
        pulse(2);
        repeat (8) @(posedge clk);
        check("group gated", {31'h0, irq_request}, 32'h0);
        chk_rd("periph flag", irq_ctrl_pkg::OFF_FLA, 32'h01);
        wr(irq_ctrl_pkg::OFF_CTRL, 8'hE0);
        wait_load(8'h03);
        chk_rd("periph entry", irq_ctrl_pkg::OFF_CTRL, 32'h60);
        wr(irq_ctrl_pkg::OFF_FLA, 8'h00);
        pulse(1);
        wait_load(8'h04);
        wr(irq_ctrl_pkg::OFF_OPT, 8'h00);
        @(posedge clk);
        ext_pin <= 1'b0;
        repeat (8) @(posedge clk);
        chk_rd("falling edge", irq_ctrl_pkg::OFF_CTRL, 32'hE2);
        check("pin disabled", {24'h0, n_load}, 32'h04);
        wr(irq_ctrl_pkg::OFF_CTRL, 8'hE0);
        ext_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk_rd("rising ignored", irq_ctrl_pkg::OFF_CTRL, 32'hE0);
        wr(irq_ctrl_pkg::OFF_CTRL, 8'h20);
        sleep_mode <= 1'b1;
        pulse(0);
        repeat (4) @(posedge clk);
        check("wake", {31'h0, wake}, 32'h1);
        check("no vector", {24'h0, n_load}, 32'h04);
        sleep_mode <= 1'b0;
        wr(irq_ctrl_pkg::OFF_CTRL, 8'hA4);
        wait_load(8'h05);
        wr(irq_ctrl_pkg::OFF_CTRL, 8'h20);
        pulse(1);
        wait_load(8'h06);
        // Asleep with the global enable set: the core must still vector, one cycle late.
        sleep_mode <= 1'b1;
        wr(irq_ctrl_pkg::OFF_CTRL, 8'hA0);
        pulse(0);
        repeat (2) @(posedge clk);
        check("sleep request", {31'h0, irq_request}, 32'h1);
        check("sleep wake", {31'h0, wake}, 32'h1);
        wait_load(8'h07);
        check("sleep vector", {19'h0, cur_pc}, 32'h0004);
        end_of_test();
    end
endmodule
